// File: rtl/cansf_pkg.sv
// Constants, field layout and state codes of the CAN status flag block.
// Assumes a 32-bit word bus with registers at word-aligned byte offsets.
package cansf_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_MCTRL = 8'h00;
  localparam logic [7:0] OFS_MSTAT = 8'h04;
  localparam logic [7:0] OFS_TSTAT = 8'h08;
  localparam logic [7:0] OFS_RQ0 = 8'h0C;
  localparam logic [7:0] OFS_IEN = 8'h14;
  // Master control fields
  localparam int MC_INIT = 0;
  localparam int MC_SLEEP = 1;
  localparam int MC_LOCK = 3;
  localparam int MC_AWAKE = 5;
  localparam int MC_DBG = 16;
  localparam logic [31:0] MC_RESET = 32'h0001_0002;
  // Master status fields
  localparam int MS_INIT_ACK = 0;
  localparam int MS_SLEEP_ACK = 1;
  localparam int MS_ERR = 2;
  localparam int MS_WAKE = 3;
  localparam int MS_SAMP = 10;
  localparam int MS_RX = 11;
  // Transmit status fields; the MB_ fields repeat per mailbox at MB_STRIDE * index
  localparam int MB_STRIDE = 8;
  localparam int MB_RQCP = 0;
  localparam int MB_TXOK = 1;
  localparam int MB_ALST = 2;
  localparam int MB_TERR = 3;
  localparam int MB_ABRQ = 7;
  localparam int TS_CODE = 24;
  localparam int TS_TME = 26;
  localparam int TS_LOW = 29;
  localparam logic [31:0] TS_RESET = 32'h1C00_0000;
  // Receive queue fields
  localparam int RQ_FULL = 3;
  localparam int RQ_OVR = 4;
  localparam int RQ_REL = 5;
  localparam logic [1:0] RQ_DEPTH = 2'h3;
  // Interrupt enable fields; bits 8..11 gate error status events
  localparam int IE_ERRSRC = 8;
  localparam int IE_ERR = 15;
  localparam int IE_WAKE = 16;
  localparam int IE_SLK = 17;
  localparam logic [31:0] IE_RESET = 32'h0000_0000;
  // Recessive bits needed to synchronise to the bus
  localparam logic [3:0] SYNC_BITS = 4'hB;
  // Operating modes
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_INIT = 2'b01,
    MODE_SLEEP = 2'b10,
    MODE_SYNC = 2'b11
  } cansf_mode_t;
endpackage

// File: rtl/cansf_status.sv
// Status flag logic of a CAN controller: mode acks, transmit status, queue 0 status.
// Assumes the rest of the controller supplies bit ticks, attempt results and queue events
// on ref_clk; the CAN receive pin is asynchronous.
`timescale 1ns/1ps
`default_nettype none
module cansf_status #(
  parameter int MAILBOXES = 3
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // CAN pin and bit timing
  input wire logic canRx,
  input wire logic bitTick,
  input wire logic sofDetect,
  input wire logic busActive,
  // Error status events: warning, passive, bus-off, last error code
  input wire logic [3:0] errEvent,
  // Transmit mailboxes
  input wire logic [2:0] txPending,
  input wire logic [2:0] txRequestSet,
  input wire logic [2:0] txAttemptDone,
  input wire logic attemptOk,
  input wire logic attemptBusErr,
  input wire logic attemptArbLost,
  input wire logic [2:0] txRequestDone,
  input wire logic [1:0] lowPrioIdx,
  output logic [2:0] abortReq,
  // Receive queue 0
  input wire logic rxAccepted,
  output logic rxStore,
  output logic rxOverwrite,
  output logic rxRelease,
  // Mode and interrupt
  output logic sleepMode,
  output logic initMode,
  output logic statusIrq
);
  if (MAILBOXES != 3) begin : gBadCount
    $error("cansf_status supports exactly three mailboxes");
  end

  // ****************************************
  // Pin synchroniser
  // ****************************************
  logic rxMeta_reg, rxSync_reg, sampBit_reg, sampBit_next;
  always_comb begin
    sampBit_next = bitTick ? rxSync_reg : sampBit_reg;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxMeta_reg <= 1'b1;
      rxSync_reg <= 1'b1;
      sampBit_reg <= 1'b1;
    end else begin
      rxMeta_reg <= canRx;
      rxSync_reg <= rxMeta_reg;
      sampBit_reg <= sampBit_next;
    end
  end

  // ****************************************
  // Bus slave
  // ****************************************
  logic wrPend_reg, wrPend_next;
  logic [7:0] wrAddr_reg, wrAddr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic addrPhase, wrEn;
  logic [31:0] mctrl_reg, mctrl_next, ien_reg, ien_next;
  logic [31:0] mstatView, tstatView, rqView;
  localparam logic [7:0] OFS_MCTRL_A = cansf_pkg::OFS_MCTRL;
  localparam logic [7:0] OFS_MSTAT_A = cansf_pkg::OFS_MSTAT;
  localparam logic [7:0] OFS_TSTAT_A = cansf_pkg::OFS_TSTAT;
  localparam logic [7:0] OFS_RQ0_A = cansf_pkg::OFS_RQ0;
  localparam logic [7:0] OFS_IEN_A = cansf_pkg::OFS_IEN;
  assign addrPhase = hsel && htrans[1] && hready;
  assign wrEn = wrPend_reg;
  always_comb begin
    wrPend_next = addrPhase && hwrite && (hsize == 3'h2);
    wrAddr_next = addrPhase ? haddr : wrAddr_reg;
    hrdata_next = hrdata_reg;
    if (addrPhase && !hwrite) begin
      case (haddr)
        OFS_MCTRL_A: hrdata_next = mctrl_reg;
        OFS_MSTAT_A: hrdata_next = mstatView;
        OFS_TSTAT_A: hrdata_next = tstatView;
        OFS_RQ0_A: hrdata_next = rqView;
        OFS_IEN_A: hrdata_next = ien_reg;
        default: hrdata_next = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      wrPend_reg <= wrPend_next;
      wrAddr_reg <= wrAddr_next;
      hrdata_reg <= hrdata_next;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
  assign hrdata = hrdata_reg;

  logic wrMctrl, wrMstat, wrTstat, wrRq, wrIen;
  assign wrMctrl = wrEn && (wrAddr_reg == OFS_MCTRL_A);
  assign wrMstat = wrEn && (wrAddr_reg == OFS_MSTAT_A);
  assign wrTstat = wrEn && (wrAddr_reg == OFS_TSTAT_A);
  assign wrRq = wrEn && (wrAddr_reg == OFS_RQ0_A);
  assign wrIen = wrEn && (wrAddr_reg == OFS_IEN_A);

  // ****************************************
  // Control registers and mode sequencer
  // ****************************************
  localparam logic [31:0] MC_MASK = (32'h1 << cansf_pkg::MC_INIT) |
    (32'h1 << cansf_pkg::MC_SLEEP) | (32'h1 << cansf_pkg::MC_LOCK) |
    (32'h1 << cansf_pkg::MC_AWAKE) | (32'h1 << cansf_pkg::MC_DBG);
  localparam logic [31:0] IE_MASK = 32'h0003_8F00;
  cansf_pkg::cansf_mode_t mode_reg, mode_next;
  logic [3:0] recCnt_reg, recCnt_next;
  logic sleep_ack_reg, sleep_ack_next, init_ack_reg, init_ack_next;
  logic wake_reg, wake_next, err_reg, err_next;
  logic sleepReq, initReq, errHit;
  assign sleepReq = mctrl_reg[cansf_pkg::MC_SLEEP];
  assign initReq = mctrl_reg[cansf_pkg::MC_INIT];
  assign errHit = |(errEvent & ien_reg[cansf_pkg::IE_ERRSRC +: 4]);
  always_comb begin
    mctrl_next = wrMctrl ? (hwdata & MC_MASK) : mctrl_reg;
    if (mode_reg == cansf_pkg::MODE_SLEEP && sofDetect && mctrl_reg[cansf_pkg::MC_AWAKE]) begin
      mctrl_next[cansf_pkg::MC_SLEEP] = 1'b0;
    end
    ien_next = wrIen ? (hwdata & IE_MASK) : ien_reg;
    wake_next = wake_reg;
    if (wrMstat && hwdata[cansf_pkg::MS_WAKE]) begin
      wake_next = 1'b0;
    end
    if (mode_reg == cansf_pkg::MODE_SLEEP && sofDetect) begin
      wake_next = 1'b1;
    end
    err_next = err_reg;
    if (wrMstat && hwdata[cansf_pkg::MS_ERR]) begin
      err_next = 1'b0;
    end
    if (errHit) begin
      err_next = 1'b1;
    end
    mode_next = mode_reg;
    recCnt_next = recCnt_reg;
    sleep_ack_next = sleep_ack_reg;
    init_ack_next = init_ack_reg;
    case (mode_reg)
      cansf_pkg::MODE_NORMAL: begin
        if (initReq && !busActive) begin
          mode_next = cansf_pkg::MODE_INIT;
          init_ack_next = 1'b1;
        end else if (sleepReq && !busActive) begin
          mode_next = cansf_pkg::MODE_SLEEP;
          sleep_ack_next = 1'b1;
        end
      end
      cansf_pkg::MODE_INIT: begin
        if (!initReq) begin
          mode_next = sleepReq ? cansf_pkg::MODE_SLEEP : cansf_pkg::MODE_SYNC;
          init_ack_next = !sleepReq;
          sleep_ack_next = sleepReq;
          recCnt_next = 4'h0;
        end
      end
      cansf_pkg::MODE_SLEEP: begin
        if (initReq) begin
          mode_next = cansf_pkg::MODE_INIT;
          init_ack_next = 1'b1;
          sleep_ack_next = 1'b0;
        end else if (!sleepReq) begin
          mode_next = cansf_pkg::MODE_SYNC;
          recCnt_next = 4'h0;
        end
      end
      cansf_pkg::MODE_SYNC: begin
        if (initReq) begin
          mode_next = cansf_pkg::MODE_INIT;
          init_ack_next = 1'b1;
          sleep_ack_next = 1'b0;
        end else if (sleepReq) begin
          mode_next = cansf_pkg::MODE_SLEEP;
          sleep_ack_next = 1'b1;
          init_ack_next = 1'b0;
        end else if (bitTick) begin
          recCnt_next = rxSync_reg ? recCnt_reg + 4'h1 : 4'h0;
          if (rxSync_reg && (recCnt_reg + 4'h1 == cansf_pkg::SYNC_BITS)) begin
            mode_next = cansf_pkg::MODE_NORMAL;
            sleep_ack_next = 1'b0;
            init_ack_next = 1'b0;
          end
        end
      end
      default: mode_next = cansf_pkg::MODE_SLEEP;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mctrl_reg <= cansf_pkg::MC_RESET;
      ien_reg <= cansf_pkg::IE_RESET;
      mode_reg <= cansf_pkg::MODE_SLEEP;
      recCnt_reg <= 4'h0;
      sleep_ack_reg <= 1'b1;
      init_ack_reg <= 1'b0;
      wake_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      mctrl_reg <= mctrl_next;
      ien_reg <= ien_next;
      mode_reg <= mode_next;
      recCnt_reg <= recCnt_next;
      sleep_ack_reg <= sleep_ack_next;
      init_ack_reg <= init_ack_next;
      wake_reg <= wake_next;
      err_reg <= err_next;
    end
  end

  always_comb begin
    mstatView = 32'h0000_0000;
    mstatView[cansf_pkg::MS_INIT_ACK] = init_ack_reg;
    mstatView[cansf_pkg::MS_SLEEP_ACK] = sleep_ack_reg;
    mstatView[cansf_pkg::MS_ERR] = err_reg;
    mstatView[cansf_pkg::MS_WAKE] = wake_reg;
    mstatView[cansf_pkg::MS_SAMP] = sampBit_reg;
    mstatView[cansf_pkg::MS_RX] = rxSync_reg;
  end

  // ****************************************
  // Transmit mailbox status
  // ****************************************
  logic [2:0] rqcp_reg, txok_reg, alst_reg, terr_reg, abrq_reg;
  genvar m;
  generate
    for (m = 0; m < 3; m++) begin : gMbox
      localparam int B = m * cansf_pkg::MB_STRIDE;
      logic rqcpN, txokN, alstN, terrN, abrqN, clrReq;
      always_comb begin
        clrReq = (wrTstat && hwdata[B + cansf_pkg::MB_RQCP]) || txRequestSet[m];
        rqcpN = clrReq ? 1'b0 : rqcp_reg[m];
        txokN = clrReq ? 1'b0 : txok_reg[m];
        alstN = clrReq ? 1'b0 : alst_reg[m];
        terrN = clrReq ? 1'b0 : terr_reg[m];
        if (txRequestDone[m]) begin
          rqcpN = 1'b1;
        end
        if (txAttemptDone[m]) begin
          txokN = attemptOk;
          alstN = !attemptOk && attemptArbLost;
          terrN = !attemptOk && attemptBusErr;
        end
        abrqN = abrq_reg[m];
        if (wrTstat && hwdata[B + cansf_pkg::MB_ABRQ] && txPending[m]) begin
          abrqN = 1'b1;
        end
        if (!txPending[m]) begin
          abrqN = 1'b0;
        end
      end
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          rqcp_reg[m] <= 1'b0;
          txok_reg[m] <= 1'b0;
          alst_reg[m] <= 1'b0;
          terr_reg[m] <= 1'b0;
          abrq_reg[m] <= 1'b0;
        end else begin
          rqcp_reg[m] <= rqcpN;
          txok_reg[m] <= txokN;
          alst_reg[m] <= alstN;
          terr_reg[m] <= terrN;
          abrq_reg[m] <= abrqN;
        end
      end
    end
  endgenerate
  assign abortReq = abrq_reg;

  logic [2:0] lowFlags;
  logic [1:0] mbCode;
  logic multiPend;
  always_comb begin
    multiPend = (txPending[0] & txPending[1]) | (txPending[0] & txPending[2]) |
      (txPending[1] & txPending[2]);
    lowFlags = 3'h0;
    if (multiPend && lowPrioIdx != 2'h3) begin
      lowFlags[lowPrioIdx] = txPending[lowPrioIdx];
    end
    if (!txPending[0]) begin
      mbCode = 2'h0;
    end else if (!txPending[1]) begin
      mbCode = 2'h1;
    end else if (!txPending[2]) begin
      mbCode = 2'h2;
    end else begin
      mbCode = lowPrioIdx;
    end
    tstatView = 32'h0000_0000;
    tstatView[cansf_pkg::TS_LOW +: 3] = lowFlags;
    tstatView[cansf_pkg::TS_TME +: 3] = ~txPending;
    tstatView[cansf_pkg::TS_CODE +: 2] = mbCode;
    for (int k = 0; k < 3; k++) begin
      tstatView[k * cansf_pkg::MB_STRIDE + cansf_pkg::MB_RQCP] = rqcp_reg[k];
      tstatView[k * cansf_pkg::MB_STRIDE + cansf_pkg::MB_TXOK] = txok_reg[k];
      tstatView[k * cansf_pkg::MB_STRIDE + cansf_pkg::MB_ALST] = alst_reg[k];
      tstatView[k * cansf_pkg::MB_STRIDE + cansf_pkg::MB_TERR] = terr_reg[k];
      tstatView[k * cansf_pkg::MB_STRIDE + cansf_pkg::MB_ABRQ] = abrq_reg[k];
    end
  end

  // ****************************************
  // Receive queue 0 status
  // ****************************************
  logic [1:0] fmp_reg, fmp_next;
  logic full_reg, full_next, ovr_reg, ovr_next, rel_reg, rel_next;
  logic store_next, over_next, relDo_next, doStore;
  always_comb begin
    rel_next = rel_reg;
    full_next = full_reg;
    ovr_next = ovr_reg;
    store_next = 1'b0;
    over_next = 1'b0;
    relDo_next = 1'b0;
    doStore = 1'b0;
    if (wrRq && hwdata[cansf_pkg::RQ_FULL]) begin
      full_next = 1'b0;
    end
    if (wrRq && hwdata[cansf_pkg::RQ_OVR]) begin
      ovr_next = 1'b0;
    end
    if (wrRq && hwdata[cansf_pkg::RQ_REL] && fmp_reg != 2'h0) begin
      rel_next = 1'b1;
    end
    if (rel_reg) begin
      rel_next = 1'b0;
      relDo_next = 1'b1;
    end
    if (rxAccepted) begin
      if (fmp_reg == cansf_pkg::RQ_DEPTH && !rel_reg) begin
        ovr_next = 1'b1;
        over_next = !mctrl_reg[cansf_pkg::MC_LOCK];
      end else begin
        doStore = 1'b1;
        store_next = 1'b1;
      end
    end
    fmp_next = fmp_reg;
    if (doStore && !rel_reg) begin
      fmp_next = fmp_reg + 2'h1;
    end else if (rel_reg && !doStore) begin
      fmp_next = fmp_reg - 2'h1;
    end
    if (fmp_next == cansf_pkg::RQ_DEPTH && doStore) begin
      full_next = 1'b1;
    end
    rqView = 32'h0000_0000;
    rqView[1:0] = fmp_reg;
    rqView[cansf_pkg::RQ_FULL] = full_reg;
    rqView[cansf_pkg::RQ_OVR] = ovr_reg;
    rqView[cansf_pkg::RQ_REL] = rel_reg;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fmp_reg <= 2'h0;
      full_reg <= 1'b0;
      ovr_reg <= 1'b0;
      rel_reg <= 1'b0;
      rxStore <= 1'b0;
      rxOverwrite <= 1'b0;
      rxRelease <= 1'b0;
    end else begin
      fmp_reg <= fmp_next;
      full_reg <= full_next;
      ovr_reg <= ovr_next;
      rel_reg <= rel_next;
      rxStore <= store_next;
      rxOverwrite <= over_next;
      rxRelease <= relDo_next;
    end
  end

  // ****************************************
  // Mode outputs and status interrupt
  // ****************************************
  logic irq_next;
  always_comb begin
    irq_next = (wake_reg && ien_reg[cansf_pkg::IE_WAKE]) ||
      (err_reg && ien_reg[cansf_pkg::IE_ERR]) ||
      (sleep_ack_reg && ien_reg[cansf_pkg::IE_SLK]);
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      statusIrq <= 1'b0;
      sleepMode <= 1'b1;
      initMode <= 1'b0;
    end else begin
      statusIrq <= irq_next;
      sleepMode <= (mode_next == cansf_pkg::MODE_SLEEP);
      initMode <= (mode_next == cansf_pkg::MODE_INIT);
    end
  end
endmodule
`default_nettype wire

// File: test/cansf_status_chk.sv
// Port checker for the CAN status flag block.
// Assumes it is bound to cansf_status and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module cansf_status_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Watched ports
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic busActive,
  input wire logic [2:0] txPending,
  input wire logic [2:0] abortReq,
  input wire logic rxAccepted,
  input wire logic rxStore,
  input wire logic rxOverwrite,
  input wire logic sleepMode,
  input wire logic initMode
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // ************
  // Relations
  // ************
  a_bus_ready: assert property ($past(rst_n) |-> hreadyout)
    else $error("hreadyout low after reset");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not OKAY");
  a_abort_needs_pend: assert property ((abortReq & ~$past(abortReq) & ~$past(txPending)) == 3'h0)
    else $error("abort set on idle mailbox");
  a_abort_clears: assert property (|(abortReq & ~txPending) |=> (abortReq & $past(abortReq) & ~$past(txPending)) == 3'h0)
    else $error("abort kept on empty mailbox");
  a_store_cause: assert property (rxStore |-> $past(rxAccepted))
    else $error("store without accepted message");
  a_overwrite_cause: assert property (rxOverwrite |-> $past(rxAccepted))
    else $error("overwrite without accepted message");
  a_store_excl: assert property (!(rxStore && rxOverwrite))
    else $error("store and overwrite together");
  a_mode_excl: assert property (!(sleepMode && initMode))
    else $error("sleep and init together");
  a_sleep_idle: assert property ($rose(sleepMode) |-> !$past(busActive))
    else $error("sleep entered during frame");
  a_init_idle: assert property ($rose(initMode) |-> !$past(busActive))
    else $error("init entered during frame");
endmodule
bind cansf_status cansf_status_chk chk_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .hreadyout(hreadyout), .hresp(hresp),
  .busActive(busActive), .txPending(txPending), .abortReq(abortReq),
  .rxAccepted(rxAccepted), .rxStore(rxStore), .rxOverwrite(rxOverwrite),
  .sleepMode(sleepMode), .initMode(initMode)
);
`default_nettype wire

// File: test/cansf_node_model.sv
// Model of the other CAN nodes as seen through the transceiver.
// Assumes one clock; bit sample points run free, frames start on request.
`timescale 1ns/1ps
`default_nettype none
module cansf_node_model #(
  parameter int BIT_CYCLES = 8,
  parameter int FRAME_BITS = 20
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Frame request
  input wire logic sendFrame,
  // Bus side
  output logic canRx,
  output logic bitTick,
  output logic sofDetect,
  output logic busActive
);
  int divCnt;
  int bitCnt;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt <= 0;
      bitCnt <= 0;
      canRx <= 1'b1;
      bitTick <= 1'b0;
      sofDetect <= 1'b0;
      busActive <= 1'b0;
    end else begin
      divCnt <= (divCnt == BIT_CYCLES - 1) ? 0 : divCnt + 1;
      bitTick <= (divCnt == BIT_CYCLES - 1);
      sofDetect <= sendFrame && !busActive;
      if (sendFrame && !busActive) begin
        busActive <= 1'b1;
        bitCnt <= FRAME_BITS;
        canRx <= 1'b0;
      end else if (busActive && bitTick) begin
        // Frame bits toggle; the idle bus rests recessive
        bitCnt <= bitCnt - 1;
        busActive <= (bitCnt > 1);
        canRx <= (bitCnt > 1) ? ~canRx : 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: test/can_status_flags_tx_rx_test.sv
// Self-checking bench of the CAN status flag block.
// Assumes the design, its checker and the CAN node model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module can_status_flags_tx_rx_test;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hready, hresp, canRx, bitTick, sofDetect, busActive;
  logic sendFrame = 1'b0;
  logic [3:0] errEvent = 4'h0;
  logic [2:0] txPending = 3'h0;
  logic [2:0] txRequestSet = 3'h0;
  logic [2:0] txAttemptDone = 3'h0;
  logic attemptOk = 1'b0;
  logic attemptBusErr = 1'b0;
  logic attemptArbLost = 1'b0;
  logic [2:0] txRequestDone = 3'h0;
  logic [1:0] lowPrioIdx = 2'h0;
  logic [2:0] abortReq;
  logic rxAccepted = 1'b0;
  logic rxStore, rxOverwrite, rxRelease, sleepMode, initMode, statusIrq;
  int errors = 0;
  int totalChecks = 0;
  int cycles = 0;
  cansf_status #(.MAILBOXES(3)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .canRx(canRx), .bitTick(bitTick),
    .sofDetect(sofDetect), .busActive(busActive), .errEvent(errEvent),
    .txPending(txPending), .txRequestSet(txRequestSet), .txAttemptDone(txAttemptDone),
    .attemptOk(attemptOk), .attemptBusErr(attemptBusErr), .attemptArbLost(attemptArbLost),
    .txRequestDone(txRequestDone), .lowPrioIdx(lowPrioIdx), .abortReq(abortReq),
    .rxAccepted(rxAccepted), .rxStore(rxStore), .rxOverwrite(rxOverwrite),
    .rxRelease(rxRelease), .sleepMode(sleepMode), .initMode(initMode), .statusIrq(statusIrq));
  cansf_node_model node_u (.ref_clk(ref_clk), .rst_n(rst_n), .sendFrame(sendFrame),
    .canRx(canRx), .bitTick(bitTick), .sofDetect(sofDetect), .busActive(busActive));
  always #2.5 ref_clk = ~ref_clk;
  // ************
  // Shared tasks
  // ************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rdChk(input string n, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(n, e, q & m);
  endtask
  task automatic errPulse(input logic [3:0] v);
    errEvent <= v;
    @(posedge ref_clk);
    errEvent <= 4'h0;
  endtask
  task automatic attempt(input logic [2:0] mb, input logic ok, input logic be, input logic al);
    @(posedge ref_clk);
    txAttemptDone <= mb;
    attemptOk <= ok;
    attemptBusErr <= be;
    attemptArbLost <= al;
    @(posedge ref_clk);
    txAttemptDone <= 3'h0;
  endtask
  task automatic acceptMsg(input logic [1:0] e);
    @(posedge ref_clk);
    rxAccepted <= 1'b1;
    @(posedge ref_clk);
    rxAccepted <= 1'b0;
    #1;
    chk("overwrite,store", {30'h0, e}, {30'h0, rxOverwrite, rxStore});
  endtask
  task automatic relMsg(input int n);
    int seen;
    seen = 0;
    wr(cansf_pkg::OFS_RQ0, 32'h0000_0020);
    repeat (4) begin
      #1;
      seen += rxRelease;
      @(posedge ref_clk);
    end
    chk("release pulses", n, seen);
  endtask
  // ************
  // Scenarios
  // ************
  task automatic t_reset();
    rdChk("mctrl", cansf_pkg::OFS_MCTRL, 32'hFFFF_FFFF, cansf_pkg::MC_RESET);
    rdChk("mstat", cansf_pkg::OFS_MSTAT, 32'hFFFF_FFFF, 32'h0000_0C02);
    rdChk("tstat", cansf_pkg::OFS_TSTAT, 32'hFFFF_FFFF, cansf_pkg::TS_RESET);
    rdChk("queue", cansf_pkg::OFS_RQ0, 32'hFFFF_FFFF, 32'h0);
    wr(8'h40, 32'hFFFF_FFFF);
    rdChk("unmapped", 8'h40, 32'hFFFF_FFFF, 32'h0);
    chk("sleepMode", 32'h1, {31'h0, sleepMode});
  endtask
  task automatic t_modes();
    wr(cansf_pkg::OFS_MCTRL, 32'h0);
    rdChk("sleep ack sync", cansf_pkg::OFS_MSTAT, 32'h3, 32'h2);
    cyc(120);
    rdChk("sleep ack off", cansf_pkg::OFS_MSTAT, 32'h3, 32'h0);
    wr(cansf_pkg::OFS_MCTRL, 32'h1);
    cyc(2);
    rdChk("init ack", cansf_pkg::OFS_MSTAT, 32'h3, 32'h1);
    chk("initMode", 32'h1, {31'h0, initMode});
    wr(cansf_pkg::OFS_MCTRL, 32'h0);
    rdChk("init ack sync", cansf_pkg::OFS_MSTAT, 32'h3, 32'h1);
    cyc(120);
    rdChk("init ack off", cansf_pkg::OFS_MSTAT, 32'h3, 32'h0);
  endtask
  task automatic t_wake();
    wr(cansf_pkg::OFS_IEN, 32'h0003_0000);
    wr(cansf_pkg::OFS_MCTRL, 32'h0000_0022);
    cyc(4);
    chk("sleep entry", 32'h1, {31'h0, sleepMode});
    chk("irq sleep", 32'h1, {31'h0, statusIrq});
    sendFrame <= 1'b1;
    @(posedge ref_clk);
    sendFrame <= 1'b0;
    cyc(300);
    rdChk("wake flag", cansf_pkg::OFS_MSTAT, 32'hB, 32'h8);
    chk("irq wake", 32'h1, {31'h0, statusIrq});
    rdChk("auto wake", cansf_pkg::OFS_MCTRL, 32'h2, 32'h0);
    wr(cansf_pkg::OFS_MSTAT, 32'h8);
    rdChk("wake clear", cansf_pkg::OFS_MSTAT, 32'h8, 32'h0);
    chk("irq idle", 32'h0, {31'h0, statusIrq});
  endtask
  task automatic t_error();
    wr(cansf_pkg::OFS_IEN, 32'h0000_8100);
    errPulse(4'h2);
    rdChk("err masked", cansf_pkg::OFS_MSTAT, 32'h4, 32'h0);
    errPulse(4'h1);
    rdChk("err set", cansf_pkg::OFS_MSTAT, 32'h4, 32'h4);
    chk("irq err", 32'h1, {31'h0, statusIrq});
    wr(cansf_pkg::OFS_MSTAT, 32'h4);
    rdChk("err clear", cansf_pkg::OFS_MSTAT, 32'h4, 32'h0);
  endtask
  task automatic t_tx();
    txPending <= 3'h3;
    lowPrioIdx <= 2'h1;
    rdChk("two pending", cansf_pkg::OFS_TSTAT, 32'hFF00_0000, 32'h5200_0000);
    txPending <= 3'h7;
    lowPrioIdx <= 2'h0;
    rdChk("all pending", cansf_pkg::OFS_TSTAT, 32'hFF00_0000, 32'h2000_0000);
    txPending <= 3'h1;
    rdChk("one pending", cansf_pkg::OFS_TSTAT, 32'hFF00_0000, 32'h1900_0000);
    wr(cansf_pkg::OFS_TSTAT, 32'h0000_8080);
    cyc(1);
    chk("abort set", 32'h1, {29'h0, abortReq});
    txPending <= 3'h0;
    cyc(2);
    chk("abort clear", 32'h0, {29'h0, abortReq});
    attempt(3'h1, 1'b1, 1'b0, 1'b0);
    attempt(3'h1, 1'b0, 1'b1, 1'b0);
    attempt(3'h2, 1'b0, 1'b0, 1'b1);
    attempt(3'h4, 1'b1, 1'b0, 1'b0);
    txRequestDone <= 3'h7;
    @(posedge ref_clk);
    txRequestDone <= 3'h0;
    rdChk("attempts", cansf_pkg::OFS_TSTAT, 32'h00FF_FFFF, 32'h0003_0509);
    wr(cansf_pkg::OFS_TSTAT, 32'h1);
    txRequestSet <= 3'h2;
    @(posedge ref_clk);
    txRequestSet <= 3'h0;
    rdChk("complete clear", cansf_pkg::OFS_TSTAT, 32'h00FF_FFFF, 32'h0003_0000);
  endtask
  task automatic t_queue();
    relMsg(0);
    rdChk("empty release", cansf_pkg::OFS_RQ0, 32'hFFFF_FFFF, 32'h0);
    repeat (3) acceptMsg(2'b01);
    rdChk("full", cansf_pkg::OFS_RQ0, 32'hFFFF_FFFF, 32'hB);
    acceptMsg(2'b10);
    rdChk("overrun", cansf_pkg::OFS_RQ0, 32'hFFFF_FFFF, 32'h1B);
    relMsg(1);
    rdChk("released", cansf_pkg::OFS_RQ0, 32'hFFFF_FFFF, 32'h1A);
    wr(cansf_pkg::OFS_RQ0, 32'h18);
    rdChk("flags clear", cansf_pkg::OFS_RQ0, 32'hFFFF_FFFF, 32'h2);
    wr(cansf_pkg::OFS_MCTRL, 32'h28);
    acceptMsg(2'b01);
    acceptMsg(2'b00);
    rdChk("locked", cansf_pkg::OFS_RQ0, 32'hFFFF_FFFF, 32'h1B);
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    cyc(20);
    t_reset();
    t_modes();
    t_wake();
    t_error();
    t_tx();
    t_queue();
    finish_test();
  end
endmodule
`default_nettype wire
